// >>> design/adc_cal_params.svh
/*
 * Offsets, field positions, reset values and counts of the calibration
 * sequencer. Assumes a 32-bit classic bus with byte addressing.
 */
`ifndef ADC_CAL_PARAMS_SVH
`define ADC_CAL_PARAMS_SVH

// register byte offsets
`define CAL_CTRL_OFS 8'h00
`define CAL_SLEEP_OFS 8'h04
`define CAL_WAKE_OFS 8'h08
`define CAL_STAT_OFS 8'h0C
`define CAL_TRIM_OFS 8'h10

// control register fields
`define CTRL_SOFT_TRIG 0
`define CTRL_PIN_EN 1
`define CTRL_BG_EN 2
`define CTRL_LOW_POWER_ENABLE 3
`define CTRL_LOW_POWER_TRIGGER_SELECT 4
`define CTRL_OS_EN 5
`define CTRL_DUAL 6
`define CTRL_IN_B 7
`define CTRL_STAT_SEL 8
`define CTRL_W 9

// status register fields
`define STAT_FOREGROUND_DONE_FLAG 0
`define STAT_FG_BUSY 1
`define STAT_STOPPED 2
`define STAT_SLOT_A 4
`define STAT_SLOT_B 6
`define STAT_SPARE 8

// reset values
`define CTRL_RST 9'h040
`define SLEEP_RST 16'h0400
`define WAKE_RST 16'h0040
`define TRIM_RST 16'h0080

// foreground pass last step index (cores in the pass minus one)
`define FG_CORES_2 2'h1
`define FG_CORES_3 2'h2

`endif

// >>> design/adc_cal_pkg.sv
/*
 * Types of the calibration sequencer. Assumes the _params header is
 * included by the design file for widths.
 */
package adc_cal_pkg;

    typedef enum logic [2:0] {
        PH_FG,
        PH_RUN,
        PH_SLEEP,
        PH_WAKE,
        PH_CAL,
        PH_READY
    } phase_t;

    // software-visible control bits, one per field
    typedef struct packed {
        logic status_sel;
        logic single_in_b;
        logic dual;
        logic os_en;
        logic low_power_trigger_select;
        logic low_power_enable;
        logic bg_en;
        logic pin_en;
        logic soft_trig;
    } ctrl_t;

    // entire sequencer state
    typedef struct packed {
        phase_t phase;
        ctrl_t ctrl;
        logic [15:0] sleep_dly;
        logic [15:0] wake_dly;
        logic [15:0] trim;
        logic [15:0] cnt;
        logic [1:0] step;
        logic [1:0] slot_a;
        logic [1:0] slot_b;
        logic swap_b;
        logic foreground_done_flag;
        logic calibration_stopped_signal;
        logic trig_meta;
        logic trig_sync;
        logic trig_prev;
        logic ack;
        logic [31:0] rdata;
        logic [7:0] out_a;
        logic [7:0] out_b;
        logic out_valid;
        logic [2:0] power;
        logic [5:0] cal_bank;
        logic [2:0] in_b;
        logic status;
    } seq_state_t;

endpackage

// >>> design/adc_cal_sequencer.sv
/*
 * Calibration sequencer for a three-core, six-bank interleaved
 * converter: foreground pass, background core rotation and low-power
 * background mode with automatic or manual timing.
 * Assumes a classic bus master on clk_i, an analog engine that pulses
 * cal_done_i once per core pass, and a sample strobe on clk_i that
 * marks complete output samples.
 */
// Our own choices: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "adc_cal_params.svh"

// Functional notes
// RQ1: foreground pass: cores offline, output zero
// RQ2: background mode keeps output running
// RQ3: six banks as three two-bank cores
// RQ4: dual: A->input a, B->input b
// RQ5: spare calibrated, swapped in, rotates
// RQ6: every bank of core calibrated
// RQ7: foreground pass after reset; host waits
// RQ8: trigger source chosen by pin enable
// RQ9: host sets bg, clears pin enable, soft=1
// RQ10: brief glitches allowed at core swaps
// RQ11: low power: spare off until due
// RQ12: trigger select: auto or manual timing
// RQ13: sleep delay sets spare sleep time
// RQ14: wake delay before calibration starts
// RQ15: auto: swap at once, then sleep
// RQ16: manual: asleep while trigger high
// RQ17: manual: swap when done and trigger high
// RQ18: status select 1 shows calibration_stopped_signal
// RQ19: host raises trigger early for low power
// RQ20: trim register returns factory value
// RQ21: host reads offsets after done flag
// RQ22: offset+bg: foreground calibrates all cores
// RQ23: one pass per rising trigger edge
// RQ24: swap only on sample boundary
module adc_cal_sequencer #(
    parameter int DLY_W = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic calibration_trigger_pin_i,
    input wire logic cal_done_i,
    input wire logic sample_stb_i,
    input wire logic [2:0][7:0] core_data_i,
    output logic [7:0] out_a_o,
    output logic [7:0] out_b_o,
    output logic out_valid_o,
    output logic [2:0] core_power_o,
    output logic [5:0] cal_bank_o,
    output logic [2:0] core_input_b_o,
    output logic calibration_status_pin_o
);

    // the delay counters are built 16 bits wide
    generate
        if (DLY_W != 16) begin : g_bad_width
            $error("DLY_W must be 16");
        end
    endgenerate

    adc_cal_pkg::seq_state_t st;
    adc_cal_pkg::seq_state_t next_st;

    logic trig_lvl;
    logic trig_rise;
    logic [1:0] spare;
    logic [1:0] fg_core;
    logic [1:0] fg_last;
    logic manual;
    logic bg_phase;

    // spare is the core index that neither slot holds (0+1+2 = 3)
    assign spare = 2'h3 - st.slot_a - st.slot_b;
    assign manual = st.ctrl.low_power_enable & st.ctrl.low_power_trigger_select;
    assign bg_phase = (st.phase != adc_cal_pkg::PH_FG)
        && (st.phase != adc_cal_pkg::PH_RUN);

    // RQ8 source select
    assign trig_lvl = st.ctrl.pin_en ? st.trig_sync : st.ctrl.soft_trig;
    assign trig_rise = trig_lvl & ~st.trig_prev;

    // foreground walks slot a, slot b, then the spare
    always_comb begin
        unique case (st.step)
            2'h0: fg_core = st.slot_a;
            2'h1: fg_core = st.slot_b;
            default: fg_core = spare;
        endcase
    end

    // RQ22 all three cores
    assign fg_last = (st.ctrl.os_en & st.ctrl.bg_en)
        ? `FG_CORES_3 : `FG_CORES_2;

    // next state
    always_comb begin
        logic [31:0] wmask;
        logic [1:0] cal_core;
        logic cal_on;
        wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
            {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
        cal_core = 2'h0;
        cal_on = 1'b0;
        next_st = st;
        next_st.ack = 1'b0;

        // pin passes two flops before the edge detector sees it
        next_st.trig_meta = calibration_trigger_pin_i;
        next_st.trig_sync = st.trig_meta;
        next_st.trig_prev = trig_lvl;

        // bus slave: answer one cycle after the request, then drop
        if (wb_cyc_i && wb_stb_i && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = 32'h0;
            if (wb_we_i) begin
                unique case (wb_adr_i)
                    `CAL_CTRL_OFS: next_st.ctrl =
                        (st.ctrl & ~wmask[`CTRL_W-1:0])
                        | (wb_dat_i[`CTRL_W-1:0] & wmask[`CTRL_W-1:0]);
                    // RQ13 sleep setting
                    `CAL_SLEEP_OFS: next_st.sleep_dly =
                        (st.sleep_dly & ~wmask[15:0])
                        | (wb_dat_i[15:0] & wmask[15:0]);
                    // RQ14 wake setting
                    `CAL_WAKE_OFS: next_st.wake_dly =
                        (st.wake_dly & ~wmask[15:0])
                        | (wb_dat_i[15:0] & wmask[15:0]);
                    `CAL_TRIM_OFS: next_st.trim =
                        (st.trim & ~wmask[15:0])
                        | (wb_dat_i[15:0] & wmask[15:0]);
                    default: ;
                endcase
            end else begin
                unique case (wb_adr_i)
                    `CAL_CTRL_OFS:
                        next_st.rdata[`CTRL_W-1:0] = st.ctrl;
                    `CAL_SLEEP_OFS: next_st.rdata[15:0] = st.sleep_dly;
                    `CAL_WAKE_OFS: next_st.rdata[15:0] = st.wake_dly;
                    `CAL_STAT_OFS: begin
                        next_st.rdata[`STAT_FOREGROUND_DONE_FLAG] = st.foreground_done_flag;
                        next_st.rdata[`STAT_FG_BUSY] =
                            st.phase == adc_cal_pkg::PH_FG;
                        next_st.rdata[`STAT_STOPPED] = st.calibration_stopped_signal;
                        next_st.rdata[`STAT_SLOT_A+:2] = st.slot_a;
                        next_st.rdata[`STAT_SLOT_B+:2] = st.slot_b;
                        next_st.rdata[`STAT_SPARE+:2] = spare;
                    end
                    // RQ20 factory trim readback
                    `CAL_TRIM_OFS: next_st.rdata[15:0] = st.trim;
                    default: ;
                endcase
            end
        end

        // leaving background mode abandons any spare activity
        if (!st.ctrl.bg_en && bg_phase) begin
            next_st.phase = adc_cal_pkg::PH_RUN;
            next_st.calibration_stopped_signal = 1'b0;
        end else begin
            unique case (st.phase)
                // RQ1 RQ7 foreground pass, one core at a time
                adc_cal_pkg::PH_FG: begin
                    cal_core = fg_core;
                    cal_on = 1'b1;
                    if (cal_done_i) begin
                        if (st.step == fg_last) begin
                            next_st.phase = adc_cal_pkg::PH_RUN;
                            next_st.foreground_done_flag = 1'b1;
                            next_st.step = 2'h0;
                        end else begin
                            next_st.step = st.step + 2'h1;
                        end
                    end
                end
                adc_cal_pkg::PH_RUN: begin
                    // RQ23 edges ignored while a pass runs
                    if (!st.ctrl.bg_en) begin
                        if (trig_rise) begin
                            next_st.phase = adc_cal_pkg::PH_FG;
                            next_st.foreground_done_flag = 1'b0;
                            next_st.step = 2'h0;
                        end
                    // RQ2 RQ5 full-power rotation
                    end else if (!st.ctrl.low_power_enable) begin
                        next_st.phase = adc_cal_pkg::PH_CAL;
                    // RQ12 RQ13 automatic timing
                    end else if (!st.ctrl.low_power_trigger_select) begin
                        next_st.phase = adc_cal_pkg::PH_SLEEP;
                        next_st.cnt = st.sleep_dly;
                    // RQ16 low trigger wakes the spare
                    end else if (!trig_lvl) begin
                        next_st.phase = adc_cal_pkg::PH_WAKE;
                        next_st.cnt = st.wake_dly;
                    end
                end
                adc_cal_pkg::PH_SLEEP: begin
                    if (st.cnt == 16'h0) begin
                        next_st.phase = adc_cal_pkg::PH_WAKE;
                        next_st.cnt = st.wake_dly;
                    end else begin
                        next_st.cnt = st.cnt - 16'h1;
                    end
                end
                // RQ14 settle before calibrating
                adc_cal_pkg::PH_WAKE: begin
                    if (st.cnt == 16'h0) begin
                        next_st.phase = adc_cal_pkg::PH_CAL;
                    end else begin
                        next_st.cnt = st.cnt - 16'h1;
                    end
                end
                // RQ6 spare banks against the reference
                adc_cal_pkg::PH_CAL: begin
                    cal_core = spare;
                    cal_on = 1'b1;
                    if (cal_done_i) begin
                        next_st.phase = adc_cal_pkg::PH_READY;
                        next_st.calibration_stopped_signal = 1'b1;
                    end
                end
                // RQ15 RQ17 swap when allowed, on a sample edge
                adc_cal_pkg::PH_READY: begin
                    if ((!manual || trig_lvl) && sample_stb_i) begin
                        // RQ24 RQ5 RQ10 retired core becomes spare
                        if (st.swap_b) begin
                            next_st.slot_b = spare;
                        end else begin
                            next_st.slot_a = spare;
                        end
                        next_st.swap_b = ~st.swap_b;
                        next_st.calibration_stopped_signal = 1'b0;
                        next_st.phase = adc_cal_pkg::PH_RUN;
                    end
                end
            endcase
        end

        // RQ3 RQ6 two banks per core under calibration
        next_st.cal_bank = 6'h00;
        if (cal_on) begin
            next_st.cal_bank[{cal_core, 1'b0}+:2] = 2'h3;
        end

        // RQ11 slots always on, spare only when due
        next_st.power = 3'h0;
        next_st.power[st.slot_a] = 1'b1;
        next_st.power[st.slot_b] = 1'b1;
        if (st.phase == adc_cal_pkg::PH_FG) begin
            next_st.power[spare] = st.step == `FG_CORES_3;
        end else if (st.ctrl.bg_en) begin
            next_st.power[spare] = !st.ctrl.low_power_enable
                || st.phase == adc_cal_pkg::PH_WAKE
                || st.phase == adc_cal_pkg::PH_CAL
                || st.phase == adc_cal_pkg::PH_READY;
        end

        // RQ4 input routing; spare follows the slot it will replace
        next_st.in_b = {3{st.ctrl.single_in_b}};
        if (st.ctrl.dual) begin
            next_st.in_b[st.slot_a] = 1'b0;
            next_st.in_b[st.slot_b] = 1'b1;
            next_st.in_b[spare] = st.swap_b;
        end

        // RQ1 RQ2 output data, zero while offline
        next_st.out_valid = sample_stb_i;
        if (sample_stb_i) begin
            if (st.phase == adc_cal_pkg::PH_FG) begin
                next_st.out_a = 8'h00;
                next_st.out_b = 8'h00;
            end else begin
                next_st.out_a = core_data_i[st.slot_a];
                next_st.out_b = core_data_i[st.slot_b];
            end
        end

        // RQ18 status pin select
        next_st.status = st.ctrl.status_sel ? st.calibration_stopped_signal
            : (st.phase == adc_cal_pkg::PH_FG);
    end

    // state register; reset starts the power-up pass
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
            st.phase <= adc_cal_pkg::PH_FG;
            st.ctrl <= `CTRL_RST;
            st.sleep_dly <= `SLEEP_RST;
            st.wake_dly <= `WAKE_RST;
            st.trim <= `TRIM_RST;
            st.slot_a <= 2'h0;
            st.slot_b <= 2'h1;
            st.power <= 3'h3;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign out_a_o = st.out_a;
    assign out_b_o = st.out_b;
    assign out_valid_o = st.out_valid;
    assign core_power_o = st.power;
    assign cal_bank_o = st.cal_bank;
    assign core_input_b_o = st.in_b;
    assign calibration_status_pin_o = st.status;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_fg_mid_code: // RQ1
    assert property ((st.phase == adc_cal_pkg::PH_FG) && sample_stb_i
        |=> out_valid_o && out_a_o == 8'h00 && out_b_o == 8'h00)
    else $error("output not zero during foreground pass");

    a_bg_data_flow: // RQ2
    assert property (bg_phase && sample_stb_i |=> out_valid_o
        && out_a_o == $past(core_data_i[st.slot_a]))
    else $error("data stopped during background calibration");

    a_swap_boundary: // RQ24
    assert property (!$stable({st.slot_a, st.slot_b})
        |-> $past(sample_stb_i)
        && $past(st.phase) == adc_cal_pkg::PH_READY)
    else $error("core swap off a sample boundary");

    a_fg_trigger_edge: // RQ23
    assert property (st.phase == adc_cal_pkg::PH_RUN && !st.ctrl.bg_en
        && trig_rise |=> st.phase == adc_cal_pkg::PH_FG && !st.foreground_done_flag)
    else $error("trigger edge did not start a pass");

    a_wake_before_cal: // RQ14
    assert property ($rose(st.phase == adc_cal_pkg::PH_CAL) && st.ctrl.low_power_enable
        |-> $past(st.phase) == adc_cal_pkg::PH_WAKE && $past(st.cnt) == 0)
    else $error("calibration started without wake delay");

    a_spare_asleep: // RQ11
    assert property (st.phase == adc_cal_pkg::PH_SLEEP
        && $past(st.phase) == adc_cal_pkg::PH_SLEEP
        |-> core_power_o[spare] == 1'b0)
    else $error("spare powered while asleep");

    a_manual_hold: // RQ17
    assert property (st.phase == adc_cal_pkg::PH_READY && manual
        && st.ctrl.bg_en && !trig_lvl |=> st.phase == adc_cal_pkg::PH_READY)
    else $error("manual swap without trigger high");

    a_auto_swap: // RQ15
    assert property (st.phase == adc_cal_pkg::PH_READY && st.ctrl.bg_en
        && !manual && sample_stb_i
        |=> st.phase == adc_cal_pkg::PH_RUN ##1
        st.phase == adc_cal_pkg::PH_SLEEP || !st.ctrl.low_power_enable)
    else $error("automatic swap did not follow calibration");

    a_cal_two_banks: // RQ6
    assert property (st.phase == adc_cal_pkg::PH_CAL && st.ctrl.bg_en
        |=> $countones(cal_bank_o) == 2)
    else $error("core calibration not on both banks");

    a_status_stopped: // RQ18
    assert property (st.ctrl.status_sel && st.calibration_stopped_signal
        |=> calibration_status_pin_o)
    else $error("status pin not showing stopped");

    a_power_up_pass: // RQ7
    assert property ($fell(rst_i) |-> st.phase == adc_cal_pkg::PH_FG)
    else $error("no foreground pass after reset");

endmodule
`default_nettype wire

// >>> tb/adc_cal_engine_model.sv
/*
 * Behavioural model of the analog side: calibration engine, sample
 * strobe and fixed per-core data words.
 * Assumes the sequencer drives cal_bank_i from clk_i and holds it
 * steady for the whole pass of one core.
 */
`timescale 1ns/10ps
`default_nettype none
module adc_cal_engine_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic [5:0] cal_bank_i,
    output logic cal_done_o,
    output logic sample_stb_o,
    output logic [2:0][7:0] core_data_o
);
    logic [7:0] cnt;
    logic [5:0] last;
    logic fired;
    logic [1:0] ph;

    // distinct word per core so a swap is visible at the outputs
    assign core_data_o = {8'hA2, 8'hA1, 8'hA0};

    // all banks done: one pulse per steady bank selection
    // full samples: strobe once every four cycles
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 8'h00;
            last <= 6'h00;
            fired <= 1'b0;
            cal_done_o <= 1'b0;
            ph <= 2'h0;
            sample_stb_o <= 1'b0;
        end else begin
            ph <= ph + 2'h1;
            sample_stb_o <= (ph == 2'h3);
            cal_done_o <= 1'b0;
            last <= cal_bank_i;
            // a new selection re-arms; a repeated one never pulses twice
            if (cal_bank_i != last) begin
                cnt <= 8'h00;
                fired <= 1'b0;
            end else if (cal_bank_i != 6'h00 && !fired) begin
                cnt <= cnt + 8'h01;
                if (cnt == (slow_i ? 8'h3C : 8'h0C)) begin
                    cal_done_o <= 1'b1;
                    fired <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// >>> tb/test_adc_cal_sequencer.sv
/*
 * Self-checking bench of the calibration sequencer: bus table, input
 * routing, triggers, background rotation and manual low-power mode.
 * Assumes the design files and the engine model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "adc_cal_params.svh"
module test_adc_cal_sequencer;
    typedef struct {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    logic clk_i, rst_i, cyc, stb, we, trig, slow;
    logic [7:0] adr;
    logic [31:0] dat, q, s1;
    logic [3:0] sel;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, cal_done, stb_s, out_valid_o, calibration_status_pin_o;
    logic [2:0][7:0] core_data;
    logic [7:0] out_a_o, out_b_o;
    logic [2:0] core_power_o, core_input_b_o;
    logic [5:0] cal_bank_o;
    int n_errors, cmp_count, cyc_cnt, n, k, done_cnt;
    logic [8:0] cv [3] = '{9'h040, 9'h000, 9'h080};
    logic [1:0] ce [3] = '{2'b10, 2'b00, 2'b11};
    // ordinary register accesses, unmapped and read-only places among them
    row_t rows [12] = '{
        '{0, `CAL_CTRL_OFS, 0, 32'h040}, '{0, `CAL_SLEEP_OFS, 0, 32'h400},
        '{0, `CAL_WAKE_OFS, 0, 32'h040}, '{0, `CAL_TRIM_OFS, 0, 32'h080},
        '{0, 8'h14, 0, 0}, '{1, 8'h14, 32'hFFFFFFFF, 0}, '{0, 8'h14, 0, 0},
        '{1, `CAL_TRIM_OFS, 32'hFFFF1234, 0},
        '{0, `CAL_TRIM_OFS, 0, 32'h1234},
        '{1, `CAL_STAT_OFS, 32'hFFFF, 0}, '{0, `CAL_STAT_OFS, 0, 32'h241},
        '{1, `CAL_SLEEP_OFS, 32'h2, 0}};

    adc_cal_sequencer i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .calibration_trigger_pin_i(trig),
        .cal_done_i(cal_done), .sample_stb_i(stb_s),
        .core_data_i(core_data), .out_a_o(out_a_o), .out_b_o(out_b_o),
        .out_valid_o(out_valid_o), .core_power_o(core_power_o),
        .cal_bank_o(cal_bank_o), .core_input_b_o(core_input_b_o),
        .calibration_status_pin_o(calibration_status_pin_o));
    adc_cal_engine_model i_eng (.clk_i(clk_i), .rst_i(rst_i),
        .slow_i(slow), .cal_bank_i(cal_bank_o), .cal_done_o(cal_done),
        .sample_stb_o(stb_s), .core_data_o(core_data));

    // free-running clock, 20 ns
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // hang guard and engine pulse count
    always @(posedge clk_i) begin
        cyc_cnt++;
        if (cal_done === 1'b1) done_cnt++;
        if (cyc_cnt == 20000) begin
            n_errors++;
            conclude();
        end
    end

    task conclude;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // one classic cycle; request held until ack is sampled high
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
        @(posedge clk_i);
        chk("ack drop", wb_ack_o, 1'b0);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hF;
        @(posedge clk_i);
        // only the bench's cycle guard ends a wait for ack
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        r = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task wait_stat(input logic lvl, input int lim);
        for (n = 0; n < lim && calibration_status_pin_o !== lvl; n++)
            @(posedge clk_i);
        chk("status pin", calibration_status_pin_o, lvl);
    endtask

    // main sequence
    initial begin
        rst_i = 1'b1;
        {cyc, stb, we, trig, slow} = 5'h00;
        adr = 8'h00;
        dat = 32'h0;
        sel = 4'h0;
        {n_errors, cmp_count, cyc_cnt, done_cnt} = '0;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("power", core_power_o, 3'b011);
        wait_stat(1'b1, 4);
        for (k = 0; k < 2000 && calibration_status_pin_o === 1'b1; k++) begin
            @(posedge clk_i);
            // data and status leave the same flop stage together
            if (out_valid_o === 1'b1 && calibration_status_pin_o === 1'b1)
                chk("fg data", {out_b_o, out_a_o}, 0);
        end
        chk("fg passes", done_cnt, 2);
        $display("power-up test done");
        foreach (rows[i]) begin
            wb(rows[i].w, rows[i].a, rows[i].d, q);
            if (!rows[i].w) chk("register", q, rows[i].e);
        end
        $display("register test done");
        for (k = 0; k < 3; k++) begin
            wb(1'b1, `CAL_CTRL_OFS, {23'h0, cv[k]}, q);
            repeat (2) @(posedge clk_i);
            chk("input sel", core_input_b_o[1:0], ce[k]);
        end
        $display("routing test done");
        wb(1'b1, `CAL_CTRL_OFS, 32'h042, q);
        trig <= 1'b1;
        wait_stat(1'b1, 8);
        done_cnt = 0;
        repeat (3) @(posedge clk_i);
        trig <= 1'b0;
        repeat (3) @(posedge clk_i);
        trig <= 1'b1;
        wait_stat(1'b0, 200);
        chk("fg passes", done_cnt, 2);
        wb(1'b0, `CAL_STAT_OFS, 0, q);
        chk("foreground_done_flag", q[0], 1'b1);
        wb(1'b1, `CAL_CTRL_OFS, 32'h043, q);
        repeat (8) @(posedge clk_i);
        chk("soft ignored", calibration_status_pin_o, 1'b0);
        wb(1'b1, `CAL_CTRL_OFS, 32'h040, q);
        wb(1'b1, `CAL_CTRL_OFS, 32'h041, q);
        wait_stat(1'b1, 8);
        wait_stat(1'b0, 200);
        $display("trigger test done");
        wb(1'b1, `CAL_CTRL_OFS, 32'h145, q);
        wb(1'b0, `CAL_STAT_OFS, 0, q);
        chk("spare", q[9:8], 2'h2);
        wait_stat(1'b1, 200);
        wait_stat(1'b0, 40);
        wb(1'b0, `CAL_STAT_OFS, 0, q);
        chk("rotation", q, 32'h061);
        // slow pass keeps the next swap out of the window
        slow <= 1'b1;
        k = 0;
        repeat (40) begin
            @(posedge clk_i);
            if (out_valid_o === 1'b1) k++;
        end
        chk("valid count", k, 10);
        chk("slot a word", out_a_o, 8'hA2);
        chk("slot b word", out_b_o, 8'hA1);
        wait_stat(1'b1, 400);
        wait_stat(1'b0, 40);
        wb(1'b0, `CAL_STAT_OFS, 0, q);
        chk("rotation", q, 32'h121);
        chk("slot b word", out_b_o, 8'hA0);
        slow <= 1'b0;
        $display("background test done");
        wb(1'b1, `CAL_CTRL_OFS, 32'h140, q);
        wb(1'b1, `CAL_CTRL_OFS, 32'h15D, q);
        repeat (30) @(posedge clk_i);
        chk("spare asleep", 32'($countones(core_power_o)), 2);
        wb(1'b0, `CAL_STAT_OFS, 0, s1);
        wb(1'b1, `CAL_CTRL_OFS, 32'h15C, q);
        wait_stat(1'b1, 400);
        chk("spare awake", 32'($countones(core_power_o)), 3);
        repeat (30) @(posedge clk_i);
        chk("swap held", calibration_status_pin_o, 1'b1);
        wb(1'b1, `CAL_CTRL_OFS, 32'h15D, q);
        wait_stat(1'b0, 40);
        wb(1'b0, `CAL_STAT_OFS, 0, q);
        chk("swapped", q[5:4] == s1[9:8] || q[7:6] == s1[9:8], 1);
        // automatic low power: short delays, swap then sleep
        wb(1'b1, `CAL_WAKE_OFS, 32'h2, q);
        wb(1'b1, `CAL_CTRL_OFS, 32'h14D, q);
        wait_stat(1'b1, 100);
        wait_stat(1'b0, 40);
        @(posedge clk_i);
        chk("retired asleep", 32'($countones(core_power_o)), 2);
        $display("low-power test done");
        conclude();
    end
endmodule
`default_nettype wire
